/* File: cfps_consts.svh */
/*
  Constants for the CPU-side data port and SIE-side buffer status block:
  register offsets, field positions, the reset value and the count width.
  Assumes it is included by bare name from the package and design files.
*/
// Functional notes
// - Data port read on OUT endpoint returns next received data word.
// - Data port write on IN endpoint places transmit data into buffer.
// - In 8-bit mode, by control bit or width pin, upper byte is invalid.
// - 16-bit mode tracks single-byte writes; odd count sent via buffer-valid.
// - Force toggle on OUT ends SIE receive, swaps buffers, sets buffer-valid; the code acts on it only while CONTINUOUS_MODE_IN is set.
// - Forced toggle also sets the endpoint buffer-ready flag.
// - SIE buffer clear on IN endpoint empties the SIE-side buffer.
// - Read-only SIE not-ready flag; one forbids toggle and clear writes.
// - Eleven-bit SIE receive byte count for OUT, updated after each ACK.
// - SIE status register acts on the CPU endpoint select choice.
// - On OUT, set buffer-valid means CPU-side data is ready to read.
// - On IN, writing buffer-valid forces completion, short or zero packet.
`ifndef CFPS_CONSTS_SVH
`define CFPS_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CFPS_DATA_PORT_OFS    8'h44
`define CFPS_SIE_STATUS_OFS   8'h46

// ****************************************************************
// Status register fields and reset value
// ****************************************************************
`define CFPS_TOGGLE_BIT       13
`define CFPS_SIE_BUFFER_CLEAR_BIT         12
`define CFPS_SREQ_BIT         11
`define CFPS_CNT_MSB          10
`define CFPS_STATUS_RST       16'h0000
`define CFPS_COUNT_W          11

`endif

/* File: cfps_pkg.sv */
/*
  Types shared by the data port block.
  Assumes the constants header is available by bare name.
*/
`include "cfps_consts.svh"
package cfps_pkg;
  typedef enum logic [1:0] {
    CFPS_IDLE  = 2'b00,
    CFPS_READ  = 2'b01,
    CFPS_WRITE = 2'b10
  } cfps_port_op_t;
endpackage

/* File: cfps_byte_lane.sv */
/*
  One byte lane of the data port: registers a byte and its valid mark.
  Assumes a synchronous enable from the parent port logic.
*/
`timescale 1ns/1ps
`default_nettype none
module cfps_byte_lane
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       load_in,
  input  wire logic       valid_in,
  input  wire logic [7:0] data_in,
  output var  logic [7:0] data_out,
  output var  logic       valid_out
);
  // Lane holds last moved byte and whether it carried meaning.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      data_out  <= 8'h00;
      valid_out <= 1'b0;
    end
    else if (load_in)
    begin
      data_out  <= valid_in ? data_in : 8'h00;
      valid_out <= valid_in;
    end
  end
endmodule // cfps_byte_lane
`default_nettype wire

/* File: cfps_port.sv */
/*
  CPU-side data port and SIE-side buffer status register.
  Assumes the CPU bus is synchronous to CLOCK_IN, the buffer manager answers
  ready flags, and the SIE engine supplies count updates and not-ready state.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfps_consts.svh"
module cfps_port
(
  // Clock and reset.
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  // CPU register bus.
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic        RD_STB_IN,
  input  wire logic        WR_STB_IN,
  input  wire logic [15:0] WDATA_IN,
  input  wire logic [1:0]  WR_BYTE_EN_IN,
  output logic      [15:0] RDATA_OUT,
  // Port width: control bit or byte-width pin.
  input  wire logic        MODE8_BIT_IN,
  input  wire logic        BYTE_WIDTH_IN,
  // Endpoint context from the select and control registers; CPU-side buffer head word.
  input  wire logic        ENDPOINT_DIRECTION_IN,
  input  wire logic        CONTINUOUS_MODE_IN,
  input  wire logic [15:0] CPU_RX_DATA_IN,
  // SIE engine status.
  input  wire logic        SIE_NOT_READY_IN,
  input  wire logic        SIE_ACK_SENT_IN,
  input  wire logic [10:0] SIE_ACK_COUNT_IN,
  // Buffer manager requests.
  output logic             CPU_RD_POP_OUT,
  output logic             CPU_WR_PUSH_OUT,
  output logic      [15:0] CPU_TX_DATA_OUT,
  output logic      [1:0]  CPU_TX_BYTES_OUT,
  output logic             FORCE_TOGGLE_OUT,
  output logic             SET_BUFFER_VALID_OUT,
  output logic             SET_BUFFER_READY_OUT,
  output logic             SIE_BUFFER_CLEAR_OUT
);
  import cfps_pkg::*;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic        mode8;
  logic        sel_data;
  logic        sel_stat;
  logic        is_in;
  logic [10:0] sie_count_r;
  logic [7:0]  lo_byte;
  logic        lo_valid;
  logic [7:0]  hi_byte;
  logic        hi_valid;
  logic        tx_load;
  cfps_port_op_t op;

  assign mode8    = MODE8_BIT_IN | BYTE_WIDTH_IN;
  assign sel_data = (ADDR_IN == `CFPS_DATA_PORT_OFS);
  assign sel_stat = (ADDR_IN == `CFPS_SIE_STATUS_OFS);
  assign is_in    = ENDPOINT_DIRECTION_IN;

  // Classify port accesses; wrong direction collapses to idle.
  always_comb
  begin
    op = CFPS_IDLE;
    if (sel_data && RD_STB_IN && !is_in)
      op = CFPS_READ;
    else if (sel_data && WR_STB_IN && is_in)
      op = CFPS_WRITE;
  end

  // Transmit lanes; the upper lane never carries data in 8-bit mode.
  assign tx_load = (op == CFPS_WRITE);
  cfps_byte_lane u_lane_lo
  (
    .clk_in    (CLOCK_IN),
    .rst_n_in  (RST_N_IN),
    .load_in   (tx_load),
    .valid_in  (WR_BYTE_EN_IN[0]),
    .data_in   (WDATA_IN[7:0]),
    .data_out  (lo_byte),
    .valid_out (lo_valid)
  );
  cfps_byte_lane u_lane_hi
  (
    .clk_in    (CLOCK_IN),
    .rst_n_in  (RST_N_IN),
    .load_in   (tx_load),
    .valid_in  (WR_BYTE_EN_IN[1] & ~mode8),
    .data_in   (WDATA_IN[15:8]),
    .data_out  (hi_byte),
    .valid_out (hi_valid)
  );

  // ****************************************************************
  // Port strobes to the buffer manager
  // ****************************************************************
  // Registered so each accepted port access produces exactly one pulse a cycle later.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      CPU_RD_POP_OUT  <= 1'b0;
      CPU_WR_PUSH_OUT <= 1'b0;
    end
    else
    begin
      CPU_RD_POP_OUT  <= (op == CFPS_READ);
      CPU_WR_PUSH_OUT <= tx_load;
    end
  end

  // Byte count accompanies pushes so a lone byte stays a lone byte.
  assign CPU_TX_DATA_OUT  = {hi_byte, lo_byte};
  assign CPU_TX_BYTES_OUT = {1'b0, lo_valid} + {1'b0, hi_valid};

  // ****************************************************************
  // Status register actions
  // ****************************************************************
  // Toggle and clear are refused while the SIE side is busy, in case the
  // host ignores the flag; direction guards keep forbidden writes harmless.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      FORCE_TOGGLE_OUT     <= 1'b0;
      SET_BUFFER_VALID_OUT <= 1'b0;
      SET_BUFFER_READY_OUT <= 1'b0;
      SIE_BUFFER_CLEAR_OUT <= 1'b0;
    end
    else
    begin
      FORCE_TOGGLE_OUT     <= sel_stat && WR_STB_IN && !is_in && !SIE_NOT_READY_IN
                              && CONTINUOUS_MODE_IN && WDATA_IN[`CFPS_TOGGLE_BIT];
      SET_BUFFER_VALID_OUT <= sel_stat && WR_STB_IN && !is_in && !SIE_NOT_READY_IN
                              && CONTINUOUS_MODE_IN && WDATA_IN[`CFPS_TOGGLE_BIT];
      SET_BUFFER_READY_OUT <= sel_stat && WR_STB_IN && !is_in && !SIE_NOT_READY_IN
                              && CONTINUOUS_MODE_IN && WDATA_IN[`CFPS_TOGGLE_BIT];
      SIE_BUFFER_CLEAR_OUT <= sel_stat && WR_STB_IN && is_in && !SIE_NOT_READY_IN
                              && WDATA_IN[`CFPS_SIE_BUFFER_CLEAR_BIT];
    end
  end

  // SIE receive count is refreshed on each ACK sent while the endpoint is OUT.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      sie_count_r <= 11'h000;
    else if (SIE_ACK_SENT_IN && !is_in)
      sie_count_r <= SIE_ACK_COUNT_IN;
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // IN-side port reads return zero and pop nothing.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      RDATA_OUT <= `CFPS_STATUS_RST;
    else if (op == CFPS_READ)
      RDATA_OUT <= mode8 ? {8'h00, CPU_RX_DATA_IN[7:0]} : CPU_RX_DATA_IN;
    else if (sel_data && RD_STB_IN)
      RDATA_OUT <= 16'h0000;
    else if (sel_stat && RD_STB_IN)
      RDATA_OUT <= {4'h0, SIE_NOT_READY_IN, sie_count_r};
    else
      RDATA_OUT <= 16'h0000;
  end
endmodule // cfps_port
`default_nettype wire

/* File: cfps_port_monitor.sv */
/* Checker for the data port block.
   Bound to cfps_port; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module cfps_port_monitor
(
  // Watched ports.
  input wire logic        CLOCK_IN, RST_N_IN, RD_STB_IN, WR_STB_IN, MODE8_BIT_IN,
  input wire logic        BYTE_WIDTH_IN, ENDPOINT_DIRECTION_IN, CONTINUOUS_MODE_IN,
  input wire logic        SIE_NOT_READY_IN, CPU_RD_POP_OUT, CPU_WR_PUSH_OUT,
  input wire logic        FORCE_TOGGLE_OUT, SET_BUFFER_VALID_OUT, SET_BUFFER_READY_OUT,
  input wire logic        SIE_BUFFER_CLEAR_OUT,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [1:0]  WR_BYTE_EN_IN, CPU_TX_BYTES_OUT,
  input wire logic [15:0] WDATA_IN, RDATA_OUT, CPU_RX_DATA_IN, CPU_TX_DATA_OUT
);
  // Decoded accesses.
  wire rd = RD_STB_IN && ADDR_IN == 8'h44;
  wire wd = WR_STB_IN && ADDR_IN == 8'h44;
  wire ws = WR_STB_IN && ADDR_IN == 8'h46;
  wire m8 = MODE8_BIT_IN | BYTE_WIDTH_IN;
  wire dir = ENDPOINT_DIRECTION_IN;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_tgl; ws && WDATA_IN[13] && !dir && CONTINUOUS_MODE_IN && !SIE_NOT_READY_IN; endsequence
  sequence s_swap; FORCE_TOGGLE_OUT && SET_BUFFER_VALID_OUT && SET_BUFFER_READY_OUT; endsequence
  property p_pop; rd && !dir |=> CPU_RD_POP_OUT && RDATA_OUT[7:0] == $past(CPU_RX_DATA_IN[7:0]);
  endproperty
  a_pop: assert property (p_pop) else $error("read did not pop head word");
  property p_push; wd && dir |=> CPU_WR_PUSH_OUT && CPU_TX_DATA_OUT[7:0] == $past(WDATA_IN[7:0]);
  endproperty
  a_push: assert property (p_push) else $error("write did not push");
  property p_m8; rd && m8 |=> RDATA_OUT[15:8] == 8'h00; endproperty
  a_m8: assert property (p_m8) else $error("upper byte not blank");
  property p_hi; wd && dir |=> CPU_TX_DATA_OUT[15:8] ==
    ($past(m8 || !WR_BYTE_EN_IN[1]) ? 8'h00 : $past(WDATA_IN[15:8]));
  endproperty
  a_hi: assert property (p_hi) else $error("upper transmit byte wrong");
  property p_odd; wd && dir && !m8 && WR_BYTE_EN_IN == 2'b01 |=> CPU_TX_BYTES_OUT == 2'd1;
  endproperty
  a_odd: assert property (p_odd) else $error("single byte count wrong");
  property p_tgl; s_tgl |=> s_swap; endproperty
  a_tgl: assert property (p_tgl) else $error("toggle pulses missing");
  property p_clr; ws && WDATA_IN[12] && dir && !SIE_NOT_READY_IN |=> SIE_BUFFER_CLEAR_OUT;
  endproperty
  a_clr: assert property (p_clr) else $error("clear pulse missing");
  property p_busy; ws && SIE_NOT_READY_IN |=> !FORCE_TOGGLE_OUT && !SIE_BUFFER_CLEAR_OUT;
  endproperty
  a_busy: assert property (p_busy) else $error("acted while busy");
  property p_ign; (wd && !dir) || (rd && dir) |=> !CPU_WR_PUSH_OUT && !CPU_RD_POP_OUT;
  endproperty
  a_ign: assert property (p_ign) else $error("refused access had effect");
  property p_idle; !RD_STB_IN |=> RDATA_OUT == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
endmodule // cfps_port_monitor
bind cfps_port cfps_port_monitor i_mon (.*);
`default_nettype wire

/* File: cfps_buf_model.sv */
/* Buffer manager model giving the head word of the CPU-side buffer.
   Assumes pops come as one-cycle pulses on the port clock. */
`timescale 1ns/1ps
`default_nettype none
module cfps_buf_model
(
  // Clock, reset and pop.
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        pop_in,
  // Head word.
  output logic      [15:0] head_out
);
  logic [7:0] idx_r;
  // Every pop shows a new word, so a stale head reads back wrong.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      idx_r <= 8'h00;
    else if (pop_in)
      idx_r <= idx_r + 8'h01;
  end
  assign head_out = {~idx_r, idx_r};
endmodule // cfps_buf_model
`default_nettype wire

/* File: cfps_port_tb.sv */
/* Self-checking bench for the data port block.
   Assumes the checker is bound and the buffer model feeds the head word. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module cfps_port_tb;
  logic CLOCK_IN = 1'b0, RST_N_IN = 1'b0, RD_STB_IN = 1'b0, WR_STB_IN = 1'b0;
  logic MODE8_BIT_IN = 1'b0, BYTE_WIDTH_IN = 1'b0, ENDPOINT_DIRECTION_IN = 1'b0;
  logic CONTINUOUS_MODE_IN = 1'b0, SIE_NOT_READY_IN = 1'b0, SIE_ACK_SENT_IN = 1'b0;
  logic [7:0] ADDR_IN = 8'h00, idx = 8'h00;
  logic [1:0] WR_BYTE_EN_IN = 2'b11, CPU_TX_BYTES_OUT;
  logic [10:0] SIE_ACK_COUNT_IN = 11'h000;
  logic [15:0] WDATA_IN = 16'h0000, RDATA_OUT, CPU_RX_DATA_IN, CPU_TX_DATA_OUT;
  logic CPU_RD_POP_OUT, CPU_WR_PUSH_OUT, FORCE_TOGGLE_OUT, SET_BUFFER_VALID_OUT;
  logic SET_BUFFER_READY_OUT, SIE_BUFFER_CLEAR_OUT, m8;
  logic [31:0] lfsr = 32'h0000_dbb3, want, notes [$];
  int fail_count = 0, total_checks = 0, cyc = 0, i;
  wire [31:0] obs = {CPU_RD_POP_OUT, CPU_WR_PUSH_OUT, FORCE_TOGGLE_OUT, SET_BUFFER_VALID_OUT,
    SET_BUFFER_READY_OUT, SIE_BUFFER_CLEAR_OUT,
    CPU_WR_PUSH_OUT ? {CPU_TX_BYTES_OUT, CPU_TX_DATA_OUT[7:0]} : 10'h000, RDATA_OUT};
  cfps_port i_dut (.*);
  cfps_buf_model i_buf (.clk_in(CLOCK_IN), .rst_n_in(RST_N_IN), .pop_in(CPU_RD_POP_OUT),
    .head_out(CPU_RX_DATA_IN));
  // Clock at 20 MHz.
  always #25 CLOCK_IN = ~CLOCK_IN;
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Strobes stay up between accesses so back-to-back cycles are exercised.
  task bus(input logic r, input logic [7:0] a, input logic [15:0] d, input logic [1:0] be,
    input logic [31:0] e);
    RD_STB_IN = r;
    WR_STB_IN = !r;
    ADDR_IN = a;
    WDATA_IN = d;
    WR_BYTE_EN_IN = be;
    @(posedge CLOCK_IN);
    #1;
    notes.push_back(e);
  endtask
  // Results stand from the taking edge; the next falling edge, half a cycle on, sees them settled.
  always @(negedge CLOCK_IN)
  begin
    cyc++;
    if (cyc > 500)
    begin
      fail_count++;
      stop_test();
    end
    if (notes.size() > 0)
    begin
      want = notes.pop_front();
      `CHK("port", want, obs)
    end
  end
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge CLOCK_IN);
    #1 RST_N_IN = 1'b1;
    @(posedge CLOCK_IN);
    #1 lfsr = rnd(lfsr);
    SIE_ACK_SENT_IN = 1'b1;
    SIE_ACK_COUNT_IN = lfsr[10:0];
    @(posedge CLOCK_IN);
    #1 SIE_ACK_SENT_IN = 1'b0;
    for (i = 0; i < 2; i++)
    begin
      SIE_NOT_READY_IN = i[0];
      bus(1'b1, 8'h46, 16'h0000, 2'b11, {16'h0000, 4'h0, i[0], SIE_ACK_COUNT_IN});
    end
    bus(1'b1, 8'h48, 16'h0000, 2'b11, 32'h0000_0000);
    for (i = 0; i < 8; i++)
    begin
      // The model buffer is always ready, so the CPU-side flag is never set here.
      MODE8_BIT_IN = i[0];
      BYTE_WIDTH_IN = i[1];
      ENDPOINT_DIRECTION_IN = i[2];
      m8 = i[0] | i[1];
      bus(1'b1, 8'h44, 16'h0000, 2'b11,
        i[2] ? 32'h0000_0000 : {6'h20, 10'h000, m8 ? 8'h00 : ~idx, idx});
      idx = idx + {7'h00, !i[2]};
      lfsr = rnd(lfsr);
      bus(1'b0, 8'h44, lfsr[15:0], 2'b11,
        i[2] ? {6'h10, m8 ? 2'd1 : 2'd2, lfsr[7:0], 16'h0000} : 32'h0000_0000);
    end
    MODE8_BIT_IN = 1'b0;
    BYTE_WIDTH_IN = 1'b0;
    bus(1'b0, 8'h44, 16'h1234, 2'b01, {6'h10, 2'd1, 8'h34, 16'h0000});
    for (i = 0; i < 16; i++)
    begin
      // Forbidden host writes are sent on purpose to prove they have no effect.
      ENDPOINT_DIRECTION_IN = i[0];
      CONTINUOUS_MODE_IN = i[1];
      SIE_NOT_READY_IN = i[2];
      bus(1'b0, 8'h46, i[3] ? 16'h2000 : 16'h1000, 2'b11,
        {2'b00, {3{i[3] & !i[0] & i[1] & !i[2]}}, !i[3] & i[0] & !i[2], 26'h000_0000});
    end
    RD_STB_IN = 1'b0;
    WR_STB_IN = 1'b0;
    repeat (3) @(posedge CLOCK_IN);
    stop_test();
  end
endmodule // cfps_port_tb
`default_nettype wire
